// ==== pkg/tfs_pkg.sv ====
// Shared constants and types for the thermal and undervoltage fault supervisor.
package tfs_pkg;

  // Clock period of the supervisor clock in nanoseconds.
  localparam int unsigned CLOCK_PERIOD_NS = 5;
  localparam int unsigned NS_PER_US = 1000;
  localparam int unsigned NS_PER_MS = 1000000;

  // Thermal recovery time, and derived cycle count.
  localparam int unsigned THERMAL_RECOVERY_MS = 300;
  localparam int unsigned THERMAL_RECOVERY_CYCLES = (THERMAL_RECOVERY_MS * NS_PER_MS) / CLOCK_PERIOD_NS;

  // Undervoltage filter time; a least time, so the cycle count rounds up.
  localparam int unsigned UV_FILTER_US = 30;
  localparam int unsigned UV_FILTER_CYCLES = (UV_FILTER_US * NS_PER_US + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // Undervoltage sleep time and selective wake time.
  localparam int unsigned UV_SLEEP_MS = 200;
  localparam int unsigned UV_SLEEP_CYCLES = (UV_SLEEP_MS * NS_PER_MS) / CLOCK_PERIOD_NS;
  localparam int unsigned SEL_WAKE_MS = 10;
  localparam int unsigned SEL_WAKE_CYCLES = (SEL_WAKE_MS * NS_PER_MS) / CLOCK_PERIOD_NS;

  // Mode change request codes from the host.
  localparam logic [1:0] REQ_NORMAL = 2'h0;
  localparam logic [1:0] REQ_STANDBY = 2'h1;
  localparam logic [1:0] REQ_SLEEP = 2'h2;

  // Fail-safe entry cause codes.
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_THERMAL = 3'h1;
  localparam logic [2:0] CAUSE_CC_UV = 3'h2;
  localparam logic [2:0] CAUSE_CC_OV = 3'h3;
  localparam logic [2:0] CAUSE_IO_UV = 3'h4;

  // Device operating states.
  typedef enum logic [2:0] {ST_NORMAL, ST_STANDBY, ST_SLEEP, ST_FAILSAFE, ST_THERMAL} tfs_state_t;
  localparam tfs_state_t RESET_STATE = ST_STANDBY;

endpackage

// ==== hdl/tfs_filter.sv ====
// Persistence filter that passes a level only after it has lasted longer than a set time.
module tfs_filter #(
  parameter int unsigned CYCLES = 16
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_level,
  output logic o_level
);

  logic [31:0] cnt_q;
  wire at_limit = (cnt_q == 32'(CYCLES));

  // Count while the level holds; any drop restarts the count and clears the output.
  always_ff @(posedge i_clock) begin
    if (i_reset || !i_level) begin
      cnt_q <= 32'h0;
      o_level <= 1'b0;
    end else begin
      if (!at_limit) begin
        cnt_q <= cnt_q + 32'h1;
      end
      o_level <= at_limit; // Asserted only once the level outlasts the filter time.
    end
  end

  chk_dip_ignored: assert property (@(posedge i_clock) disable iff (i_reset)
    !i_level |=> !o_level) else $error("filter output stayed high after the level dropped");

endmodule

// ==== hdl/tfs_timer.sv ====
// Repeating interval timer that pulses at the end of each period while it runs.
module tfs_timer #(
  parameter int unsigned CYCLES = 16
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_run,
  input wire logic i_restart,
  output logic o_expired
);

  logic [31:0] cnt_q;
  wire last = (cnt_q == 32'(CYCLES - 1));

  // Counts while running, wraps at the end of each period so a lasting fault repeats its check.
  always_ff @(posedge i_clock) begin
    if (i_reset || !i_run || i_restart) begin
      cnt_q <= 32'h0;
      o_expired <= 1'b0;
    end else begin
      cnt_q <= last ? 32'h0 : cnt_q + 32'h1;
      o_expired <= last;
    end
  end

endmodule

// ==== hdl/tfs_supervisor.sv ====
// Thermal and supply fault supervisor for a CAN FD transceiver.
// Functional notes
// - Thermal warning raises host interrupt; transceiver stays enabled.
// - Thermal trip disables transceiver, sets trip flag, raises interrupt.
// - Core and host register access stay alive during thermal trip.
// - Recovery timer starts with trip; at expiry, sleep if trip gone.
// - In thermal protected state, only sleep requests are honoured.
// - With fail-safe enabled, trip enters fail-safe instead.
// - Trip during I/O undervoltage without fail-safe goes straight to sleep.
// - Undervoltage must outlast the filter time before the sleep timer starts.
// - Sleep timer expiry with undervoltage present: fail-safe if enabled, else sleep.
// - Main supply low blocks all bus activity toward the host.
// - Main supply low forces standby, supply enable off; recovery starts wake timer.
// - Main supply at power-on-reset level clears everything.
// - Transceiver supply low runs sleep timer, then fail-safe or sleep.
// - Transceiver supply overvoltage enters fail-safe or sleep.
// - I/O supply low disconnects transceiver and runs timer toward fail-safe or sleep.
// - Sleep needs a wake event to return to standby with supply enable.
// - Sleep clears flags; a lasting I/O fault repeats the sleep cycle.
// - I/O undervoltage during thermal trip forces immediate sleep.
// - Main supply low disables wake receiver and floats receive data.
// - Fail-safe entry sets the global interrupt and records the cause.
module tfs_supervisor #(
  parameter int unsigned THERMAL_RECOVERY_CYCLES = tfs_pkg::THERMAL_RECOVERY_CYCLES,
  parameter int unsigned UV_FILTER_CYCLES = tfs_pkg::UV_FILTER_CYCLES,
  parameter int unsigned UV_SLEEP_CYCLES = tfs_pkg::UV_SLEEP_CYCLES,
  parameter int unsigned SEL_WAKE_CYCLES = tfs_pkg::SEL_WAKE_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_main_supply_por,
  input wire logic i_main_supply_low,
  input wire logic i_transceiver_supply_low,
  input wire logic i_transceiver_supply_high,
  input wire logic i_io_supply_low,
  input wire logic i_thermal_warning,
  input wire logic i_thermal_trip,
  input wire logic i_failsafe_enable,
  input wire logic i_mode_req_valid,
  input wire logic [1:0] i_mode_req,
  input wire logic i_flag_clear,
  input wire logic i_wake,
  input wire logic i_bus_rxd,
  input wire logic i_bus_wake_request,
  output logic [2:0] o_mode,
  output logic o_transceiver_enable,
  output logic o_bus_hiz,
  output logic o_rxd,
  output logic o_rxd_oe,
  output logic o_bus_wake_request,
  output logic o_wake_rx_enable,
  output logic o_external_supply_enable,
  output logic o_selective_wake_timer_run,
  output logic o_host_int_n,
  output logic o_thermal_warning_flag,
  output logic o_thermal_trip_flag,
  output logic o_io_supply_low_flag,
  output logic o_transceiver_supply_low_flag,
  output logic o_global_int_flag,
  output logic [2:0] o_failsafe_cause
);

  tfs_pkg::tfs_state_t state_q;
  tfs_pkg::tfs_state_t state_d;
  logic [2:0] cause_d;
  logic rst;
  logic main_low_f;
  logic cc_low_f;
  logic io_low_f;
  logic uv_expired;
  logic thermal_expired;
  logic swt_expired;
  logic trip_q;
  logic swt_run_q;
  logic warn_q;

  // A power-on-reset level on the main supply acts as a full clear of every register.
  assign rst = i_reset | i_main_supply_por;

  // Undervoltage inputs pass only after outlasting the filter time.
  tfs_filter #(.CYCLES(UV_FILTER_CYCLES)) u_main_filter (
    .i_clock(i_clock),
    .i_reset(rst),
    .i_level(i_main_supply_low),
    .o_level(main_low_f)
  );
  tfs_filter #(.CYCLES(UV_FILTER_CYCLES)) u_cc_filter (
    .i_clock(i_clock),
    .i_reset(rst),
    .i_level(i_transceiver_supply_low),
    .o_level(cc_low_f)
  );
  tfs_filter #(.CYCLES(UV_FILTER_CYCLES)) u_io_filter (
    .i_clock(i_clock),
    .i_reset(rst),
    .i_level(i_io_supply_low),
    .o_level(io_low_f)
  );

  // The undervoltage sleep timer runs while a filtered transceiver or I/O fault stands.
  wire uv_present = cc_low_f | io_low_f;
  tfs_timer #(.CYCLES(UV_SLEEP_CYCLES)) u_uv_sleep_timer (
    .i_clock(i_clock),
    .i_reset(rst),
    .i_run(uv_present),
    .i_restart(1'b0),
    .o_expired(uv_expired)
  );

  // The thermal recovery timer restarts with each new trip and runs in the protected state.
  wire trip_rise = i_thermal_trip & ~trip_q;
  wire in_thermal = (state_q == tfs_pkg::ST_THERMAL);
  tfs_timer #(.CYCLES(THERMAL_RECOVERY_CYCLES)) u_thermal_recovery_timer (
    .i_clock(i_clock),
    .i_reset(rst),
    .i_run(in_thermal),
    .i_restart(trip_rise),
    .o_expired(thermal_expired)
  );

  // Selective wake timer runs from the turn-on of the external supply enable until expiry or until that enable turns off.
  tfs_timer #(.CYCLES(SEL_WAKE_CYCLES)) u_selective_wake_timer (
    .i_clock(i_clock),
    .i_reset(rst),
    .i_run(swt_run_q),
    .i_restart(1'b0),
    .o_expired(swt_expired)
  );

  // Decoded conditions used by the state logic.
  wire asleep = (state_q == tfs_pkg::ST_SLEEP) || (state_q == tfs_pkg::ST_FAILSAFE);
  wire active = (state_q == tfs_pkg::ST_NORMAL) || (state_q == tfs_pkg::ST_STANDBY);
  wire req_sleep = i_mode_req_valid && (i_mode_req == tfs_pkg::REQ_SLEEP);
  wire req_normal = i_mode_req_valid && (i_mode_req == tfs_pkg::REQ_NORMAL);
  wire req_standby = i_mode_req_valid && (i_mode_req == tfs_pkg::REQ_STANDBY);
  wire fault_dest_fs = i_failsafe_enable;
  wire [2:0] uv_cause = cc_low_f ? tfs_pkg::CAUSE_CC_UV : tfs_pkg::CAUSE_IO_UV;

  // Next state, highest priority first; cause_d is non-zero on fail-safe entry and on an overvoltage sleep entry.
  always_comb begin
    state_d = state_q;
    cause_d = tfs_pkg::CAUSE_NONE;
    if (main_low_f) begin
      state_d = tfs_pkg::ST_STANDBY;
    end else if (i_transceiver_supply_high && state_q != tfs_pkg::ST_SLEEP && state_q != tfs_pkg::ST_FAILSAFE) begin
      state_d = fault_dest_fs ? tfs_pkg::ST_FAILSAFE : tfs_pkg::ST_SLEEP;
      cause_d = tfs_pkg::CAUSE_CC_OV;
    end else if (trip_rise && !asleep) begin
      if (fault_dest_fs) begin
        state_d = tfs_pkg::ST_FAILSAFE;
        cause_d = tfs_pkg::CAUSE_THERMAL;
      end else if (i_io_supply_low) begin
        state_d = tfs_pkg::ST_SLEEP;
      end else begin
        state_d = tfs_pkg::ST_THERMAL;
      end
    end else if (in_thermal) begin
      if (i_io_supply_low || req_sleep) begin
        state_d = tfs_pkg::ST_SLEEP;
      end else if (thermal_expired && !i_thermal_trip) begin
        state_d = tfs_pkg::ST_SLEEP;
      end
    end else if (uv_expired && uv_present && !asleep) begin
      state_d = fault_dest_fs ? tfs_pkg::ST_FAILSAFE : tfs_pkg::ST_SLEEP;
      cause_d = fault_dest_fs ? uv_cause : tfs_pkg::CAUSE_NONE;
    end else if (asleep) begin
      if (i_wake) begin
        state_d = tfs_pkg::ST_STANDBY;
      end
    end else if (active) begin
      if (req_sleep) begin
        state_d = tfs_pkg::ST_SLEEP;
      end else if (req_normal) begin
        state_d = tfs_pkg::ST_NORMAL;
      end else if (req_standby) begin
        state_d = tfs_pkg::ST_STANDBY;
      end
    end
  end

  // Decoded output levels, computed from the next state so they align with it.
  wire enter_sleep = (state_d == tfs_pkg::ST_SLEEP) && (state_q != tfs_pkg::ST_SLEEP);
  wire enter_fs = (state_d == tfs_pkg::ST_FAILSAFE) && (state_q != tfs_pkg::ST_FAILSAFE);
  wire xcvr_en_d = (state_d == tfs_pkg::ST_NORMAL) && !i_io_supply_low && !main_low_f;
  wire ext_en_d = !main_low_f && (state_d != tfs_pkg::ST_SLEEP);
  wire rxd_oe_d = !main_low_f && !i_io_supply_low;
  wire rxd_d = xcvr_en_d ? i_bus_rxd : 1'b1;
  wire bwr_d = i_bus_wake_request && !main_low_f;
  wire swt_start = ext_en_d && !o_external_supply_enable;

  // Flag next values: hardware sets win over a host clear; sleep entry clears held flags and masks the trip and I/O sets.
  wire clr = i_flag_clear | enter_sleep;
  wire warn_rise = i_thermal_warning & ~warn_q;
  wire warn_d = warn_rise | (o_thermal_warning_flag & ~clr);
  // A trip that sends the device straight to sleep is lost with the other flags on sleep entry.
  wire trip_flag_d = (trip_rise & ~asleep & ~enter_sleep) | (o_thermal_trip_flag & ~clr);
  wire io_flag_d = (io_low_f & ~enter_sleep) | (o_io_supply_low_flag & ~clr);
  wire cc_flag_d = cc_low_f | (o_transceiver_supply_low_flag & ~clr);
  wire glob_d = enter_fs | (o_global_int_flag & ~clr);
  wire [2:0] cause_next = enter_fs ? cause_d : (clr ? tfs_pkg::CAUSE_NONE : o_failsafe_cause);
  wire any_flag_d = warn_d | trip_flag_d | io_flag_d | cc_flag_d | glob_d;

  // State, edge history and timer run register.
  always_ff @(posedge i_clock) begin
    if (rst) begin
      state_q <= tfs_pkg::RESET_STATE;
      trip_q <= 1'b0;
      warn_q <= 1'b0;
      swt_run_q <= 1'b0;
    end else begin
      state_q <= state_d;
      trip_q <= i_thermal_trip;
      warn_q <= i_thermal_warning;
      swt_run_q <= swt_start | (swt_run_q & ~swt_expired & ext_en_d);
    end
  end

  // Status flags and the interrupt pin; all stay reachable by the host in every state.
  always_ff @(posedge i_clock) begin
    if (rst) begin
      o_thermal_warning_flag <= 1'b0;
      o_thermal_trip_flag <= 1'b0;
      o_io_supply_low_flag <= 1'b0;
      o_transceiver_supply_low_flag <= 1'b0;
      o_global_int_flag <= 1'b0;
      o_failsafe_cause <= tfs_pkg::CAUSE_NONE;
      o_host_int_n <= 1'b1;
    end else begin
      o_thermal_warning_flag <= warn_d;
      o_thermal_trip_flag <= trip_flag_d;
      o_io_supply_low_flag <= io_flag_d;
      o_transceiver_supply_low_flag <= cc_flag_d;
      o_global_int_flag <= glob_d;
      o_failsafe_cause <= cause_next;
      o_host_int_n <= ~any_flag_d;
    end
  end

  // Pin-facing controls.
  always_ff @(posedge i_clock) begin
    if (rst) begin
      o_transceiver_enable <= 1'b0;
      o_bus_hiz <= 1'b1;
      o_rxd <= 1'b1;
      o_rxd_oe <= 1'b0;
      o_bus_wake_request <= 1'b0;
      o_wake_rx_enable <= 1'b0;
      o_external_supply_enable <= 1'b0;
    end else begin
      o_transceiver_enable <= xcvr_en_d;
      o_bus_hiz <= ~xcvr_en_d;
      o_rxd <= rxd_d;
      o_rxd_oe <= rxd_oe_d;
      o_bus_wake_request <= bwr_d;
      o_wake_rx_enable <= ~main_low_f;
      o_external_supply_enable <= ext_en_d;
    end
  end

  assign o_mode = state_q;
  assign o_selective_wake_timer_run = swt_run_q;

  // Checks on the supervisor's own behaviour.
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (rst);

  chk_warn_interrupt: assert property ($rose(i_thermal_warning) && !i_flag_clear |=>
    o_thermal_warning_flag && !o_host_int_n) else $error("thermal warning did not raise the interrupt");
  chk_warn_keeps_xcvr: assert property (o_transceiver_enable && $rose(i_thermal_warning) && !i_thermal_trip &&
    !main_low_f && !i_io_supply_low && !i_transceiver_supply_high && !uv_expired && !i_mode_req_valid |=>
    o_transceiver_enable) else $error("thermal warning disabled the transceiver");
  chk_trip_shutdown: assert property (trip_rise && active && !main_low_f && !i_transceiver_supply_high &&
    (i_failsafe_enable || !i_io_supply_low) |=>
    !o_transceiver_enable && o_bus_hiz && o_thermal_trip_flag && !o_host_int_n)
    else $error("thermal trip did not shut the transceiver and interrupt");
  chk_thermal_ignore: assert property (in_thermal && (req_normal || req_standby) && !i_io_supply_low &&
    !thermal_expired && !main_low_f && !i_transceiver_supply_high |=> state_q == tfs_pkg::ST_THERMAL)
    else $error("normal or standby request accepted while thermally protected");
  chk_thermal_sleep: assert property (in_thermal && (req_sleep || i_io_supply_low) && !main_low_f &&
    !i_transceiver_supply_high |=> state_q == tfs_pkg::ST_SLEEP) else $error("thermal state did not go to sleep");
  chk_recovery_exit: assert property (in_thermal && thermal_expired && !i_thermal_trip && !main_low_f &&
    !i_transceiver_supply_high |=> state_q == tfs_pkg::ST_SLEEP) else $error("recovery expiry did not sleep");
  chk_failsafe_cause: assert property ($rose(state_q == tfs_pkg::ST_FAILSAFE) |->
    o_global_int_flag && o_failsafe_cause != tfs_pkg::CAUSE_NONE && !o_host_int_n)
    else $error("fail-safe entry without global flag or cause");
  chk_uv_timeout: assert property (uv_expired && uv_present && active && !main_low_f && !trip_rise &&
    !i_transceiver_supply_high |=> state_q == (i_failsafe_enable ? tfs_pkg::ST_FAILSAFE : tfs_pkg::ST_SLEEP))
    else $error("undervoltage timeout went to the wrong state");
  chk_main_low: assert property (main_low_f |=> state_q == tfs_pkg::ST_STANDBY && !o_external_supply_enable &&
    !o_rxd_oe && !o_wake_rx_enable && !o_bus_wake_request) else $error("main supply low not handled");
  chk_io_disconnect: assert property (i_io_supply_low |=> !o_transceiver_enable && o_bus_hiz && !o_rxd_oe)
    else $error("transceiver still connected during I/O undervoltage");
  chk_sleep_hold: assert property (state_q == tfs_pkg::ST_SLEEP && !i_wake && !main_low_f |=>
    state_q == tfs_pkg::ST_SLEEP && !o_external_supply_enable) else $error("sleep left without a wake event");
  chk_sleep_clears: assert property ($rose(state_q == tfs_pkg::ST_SLEEP) |->
    !o_io_supply_low_flag && !o_thermal_trip_flag && !o_global_int_flag) else $error("sleep entry kept flags");
  chk_cc_rxd_high: assert property (cc_low_f && asleep && !main_low_f && !i_io_supply_low |=>
    o_rxd && o_rxd_oe && o_bus_hiz)
    else $error("receive data not recessive during transceiver supply fault");

  cov_thermal_to_sleep: cover property (in_thermal ##1 state_q == tfs_pkg::ST_SLEEP);
  cov_failsafe_entry: cover property ($rose(state_q == tfs_pkg::ST_FAILSAFE));
  cov_uv_sleep: cover property (uv_expired && uv_present ##1 state_q == tfs_pkg::ST_SLEEP);
  cov_wake_timer: cover property ($rose(swt_run_q));

endmodule

// ==== tb/tfs_host_model.sv ====
// Host model that issues mode requests and flag clears toward the supervisor.
module tfs_host_model #(
  parameter int unsigned MODE_GAP = 4
) (
  input wire logic i_clock,
  input wire logic i_host_int_n,
  output logic o_mode_req_valid,
  output logic [1:0] o_mode_req,
  output logic o_flag_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned quiet;

  // Request lines start idle so nothing is taken while the supervisor leaves reset.
  initial begin
    o_mode_req_valid = 1'b0;
    o_mode_req = 2'h1;
    o_flag_clear = 1'b0;
    quiet = 0;
  end

  // Counts cycles since the interrupt line last went quiet after a fault.
  always @(posedge i_clock) begin
    quiet <= (i_host_int_n === 1'b1) ? quiet + 1 : 0;
  end

  // Issues a one-cycle request; normal mode waits out the transition time after a recovery.
  task automatic request(input logic [1:0] code);
    int n;
    n = 0;
    while (code == tfs_pkg::REQ_NORMAL && i_host_int_n === 1'b1 && quiet < MODE_GAP && n < 50) begin
      @(negedge i_clock);
      n++;
    end
    o_mode_req <= code;
    o_mode_req_valid <= 1'b1;
    @(negedge i_clock);
    o_mode_req_valid <= 1'b0;
    o_mode_req <= ~code;  // Released lines do not keep the last code.
    @(negedge i_clock);  // One idle edge so a following request never re-raises valid in this step.
  endtask

  // Pulses the flag clear for one cycle.
  task automatic clear();
    o_flag_clear <= 1'b1;
    @(negedge i_clock);
    o_flag_clear <= 1'b0;
  endtask
endmodule

// ==== tb/tfs_supervisor_test.sv ====
// Self-checking testbench for the thermal and undervoltage fault supervisor.
module tfs_supervisor_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned T_REC = 20;
  localparam int unsigned T_FLT = 4;
  localparam int unsigned T_UVS = 30;
  localparam int unsigned T_SWK = 10;
  localparam logic [2:0] M_NRM = tfs_pkg::ST_NORMAL;
  localparam logic [2:0] M_STB = tfs_pkg::ST_STANDBY;
  localparam logic [2:0] M_SLP = tfs_pkg::ST_SLEEP;
  localparam logic [2:0] M_FS = tfs_pkg::ST_FAILSAFE;
  localparam logic [2:0] M_TH = tfs_pkg::ST_THERMAL;
  logic i_clock, i_reset, por, main_low, cc_low, cc_high, io_low, warn, trip, fs_en, wake, bus_rxd, bus_wake;
  logic req_valid, flag_clear, xcvr_en, bus_hiz, rxd, rxd_oe, bwr_out, wake_rx, ext_en, swt_run, int_n;
  logic warn_f, trip_f, io_f, cc_f, glob_f;
  logic [1:0] req;
  logic [2:0] mode, cause;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed = 32'h175F;

  tfs_supervisor #(.THERMAL_RECOVERY_CYCLES(T_REC), .UV_FILTER_CYCLES(T_FLT), .UV_SLEEP_CYCLES(T_UVS),
    .SEL_WAKE_CYCLES(T_SWK)) i_dut (.i_clock(i_clock), .i_reset(i_reset), .i_main_supply_por(por),
    .i_main_supply_low(main_low), .i_transceiver_supply_low(cc_low), .i_transceiver_supply_high(cc_high),
    .i_io_supply_low(io_low), .i_thermal_warning(warn), .i_thermal_trip(trip), .i_failsafe_enable(fs_en),
    .i_mode_req_valid(req_valid), .i_mode_req(req), .i_flag_clear(flag_clear), .i_wake(wake),
    .i_bus_rxd(bus_rxd), .i_bus_wake_request(bus_wake), .o_mode(mode), .o_transceiver_enable(xcvr_en),
    .o_bus_hiz(bus_hiz), .o_rxd(rxd), .o_rxd_oe(rxd_oe), .o_bus_wake_request(bwr_out),
    .o_wake_rx_enable(wake_rx), .o_external_supply_enable(ext_en), .o_selective_wake_timer_run(swt_run),
    .o_host_int_n(int_n), .o_thermal_warning_flag(warn_f), .o_thermal_trip_flag(trip_f),
    .o_io_supply_low_flag(io_f), .o_transceiver_supply_low_flag(cc_f), .o_global_int_flag(glob_f),
    .o_failsafe_cause(cause));

  tfs_host_model i_host (.i_clock(i_clock), .i_host_int_n(int_n), .o_mode_req_valid(req_valid),
    .o_mode_req(req), .o_flag_clear(flag_clear));

  // Mode expected after a host request, from the state the request meets.
  function automatic logic [2:0] after_req(input logic [2:0] cur, input logic [1:0] code);
    if (cur == M_TH) return (code == tfs_pkg::REQ_SLEEP) ? M_SLP : M_TH;
    if (cur == M_SLP || cur == M_FS || code == 2'h3) return cur;
    if (code == tfs_pkg::REQ_NORMAL) return M_NRM;
    return (code == tfs_pkg::REQ_STANDBY) ? M_STB : M_SLP;
  endfunction

  // Where a supply fault leads, given the fail-safe setting.
  function automatic logic [2:0] fault_mode(input logic f);
    return f ? M_FS : M_SLP;
  endfunction

  task automatic check3(input string what, input logic [2:0] exp, input logic [2:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic check(input string what, input logic exp, input logic got);
    check3(what, {2'h0, exp}, {2'h0, got});
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  // Polls the mode for a bounded number of cycles, then compares it.
  task automatic wait_mode(input logic [2:0] e, input int lim);
    int n;
    n = 0;
    while (mode !== e && n < lim) begin
      tick(1);
      n++;
    end
    check3("mode", e, mode);
  endtask

  // Returns all fault inputs to idle and resets with the given fail-safe setting.
  task automatic do_reset(input logic f);
    {por, main_low, cc_low, cc_high, io_low, warn, trip, wake, bus_wake} = 9'h000;
    fs_en = f;
    i_reset = 1'b1;
    tick(2);
    i_reset = 1'b0;
    tick(2);
  endtask

  task automatic go_normal();
    i_host.request(tfs_pkg::REQ_NORMAL);
    check3("mode", M_NRM, mode);
  endtask

  task automatic wake_up();
    wake = 1'b1;
    tick(1);
    wake = 1'b0;
    check3("mode", M_STB, mode);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Free-running 200 MHz clock.
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  // Cuts a hang short well beyond the expected run length.
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      mismatches++;
      end_of_test();
    end
  end

  // Main sequence: reset, random requests, then each fault path in turn.
  initial begin
    logic [1:0] code;
    logic [2:0] e;
    int dip;
    {por, main_low, cc_low, cc_high, io_low, warn, trip, fs_en, wake, bus_rxd, bus_wake} = 11'h002;
    i_reset = 1'b1;
    tick(6);
    i_reset = 1'b0;
    tick(2);
    check3("mode", M_STB, mode);
    check("ext_en", 1'b1, ext_en);
    for (int k = 0; k < 30; k++) begin
      code = 2'($random(seed));
      e = after_req(mode, code);
      i_host.request(code);
      check3("mode", e, mode);
      bus_rxd = 1'($random(seed));
      tick(2);
      if (e == M_NRM) check("rxd", bus_rxd, rxd);
      if (e == M_SLP) begin
        check("ext_en", 1'b0, ext_en);
        wake_up();
        tick(2);
        check("ext_en", 1'b1, ext_en);
      end
    end
    go_normal();
    warn = 1'b1;
    tick(1);
    check("warn_f", 1'b1, warn_f);
    check("int_n", 1'b0, int_n);
    check("xcvr_en", 1'b1, xcvr_en);
    i_host.clear();
    check("int_n", 1'b1, int_n);
    trip = 1'b1;
    tick(1);
    check3("mode", M_TH, mode);
    check("bus_hiz", 1'b1, bus_hiz);
    check("trip_f", 1'b1, trip_f);
    check("int_n", 1'b0, int_n);
    i_host.request(tfs_pkg::REQ_NORMAL);
    check3("mode", M_TH, mode);
    i_host.request(tfs_pkg::REQ_STANDBY);
    check3("mode", M_TH, mode);
    i_host.clear();
    check("trip_f", 1'b0, trip_f);
    i_host.request(tfs_pkg::REQ_SLEEP);
    check3("mode", M_SLP, mode);
    do_reset(1'b0);
    go_normal();
    trip = 1'b1;
    tick(3);
    trip = 1'b0;
    tick(T_REC - 5);
    check3("mode", M_TH, mode);
    wait_mode(M_SLP, 8);
    do_reset(1'b1);
    go_normal();
    trip = 1'b1;
    tick(1);
    check3("mode", M_FS, mode);
    check3("cause", tfs_pkg::CAUSE_THERMAL, cause);
    check("glob_f", 1'b1, glob_f);
    wake_up();
    do_reset(1'b0);
    go_normal();
    io_low = 1'b1;
    tick(2);
    check("xcvr_en", 1'b0, xcvr_en);
    trip = 1'b1;
    tick(1);
    check3("mode", M_SLP, mode);
    do_reset(1'b0);
    go_normal();
    trip = 1'b1;
    tick(1);
    io_low = 1'b1;
    wait_mode(M_SLP, 2);
    for (int f = 0; f < 2; f++) begin
      do_reset(1'(f));
      go_normal();
      dip = 1 + ($unsigned($random(seed)) % T_FLT);
      cc_low = 1'b1;
      tick(dip);
      cc_low = 1'b0;
      tick(T_FLT + T_UVS + 5);
      check3("mode", M_NRM, mode);
      check("cc_f", 1'b0, cc_f);
      cc_low = 1'b1;
      tick(T_FLT + 4);
      check("cc_f", 1'b1, cc_f);
      tick(T_UVS - 8);
      check3("mode", M_NRM, mode);
      wait_mode(fault_mode(1'(f)), 15);
      check("bus_hiz", 1'b1, bus_hiz);
      check("rxd", 1'b1, rxd);
      check("rxd_oe", 1'b1, rxd_oe);
      if (f == 1) check3("cause", tfs_pkg::CAUSE_CC_UV, cause);
      do_reset(1'(f));
      go_normal();
      cc_high = 1'b1;
      wait_mode(fault_mode(1'(f)), 2);
      if (f == 1) check3("cause", tfs_pkg::CAUSE_CC_OV, cause);
    end
    do_reset(1'b0);
    go_normal();
    io_low = 1'b1;
    tick(T_FLT + 4);
    check("io_f", 1'b1, io_f);
    wait_mode(M_SLP, T_UVS + 10);
    wake_up();
    wait_mode(M_SLP, T_FLT + T_UVS + 12);
    do_reset(1'b0);
    go_normal();
    bus_wake = 1'b1;
    tick(2);
    check("bwr_out", 1'b1, bwr_out);
    main_low = 1'b1;
    tick(T_FLT + 2);
    check3("mode", M_STB, mode);
    check("ext_en", 1'b0, ext_en);
    check("bwr_out", 1'b0, bwr_out);
    check("wake_rx", 1'b0, wake_rx);
    check("rxd_oe", 1'b0, rxd_oe);
    main_low = 1'b0;
    tick(2);
    check("ext_en", 1'b1, ext_en);
    check("swt_run", 1'b1, swt_run);
    tick(T_SWK + 3);
    check("swt_run", 1'b0, swt_run);
    go_normal();
    warn = 1'b1;
    tick(1);
    por = 1'b1;
    tick(1);
    por = 1'b0;
    check3("mode", M_STB, mode);
    check("warn_f", 1'b0, warn_f);
    check("int_n", 1'b1, int_n);
    end_of_test();
  end
endmodule
